// ### ssr_pkg.sv
// Constants, command codes and carriers for the status event reporting block.
// Assumes one 25 MHz clock shared by the command parser and measurement engine.
//
// Operation
// RULE1: Event bits latch once set until cleared by their query or clear-status.
// RULE2: Summary bit is OR of enabled event bits; reading an enable keeps it.
// RULE3: Standard event bit 0 sets when all commands through operation-complete finish.
// RULE4: Standard event bit 2 sets on query errors of the output buffer.
// RULE5: Standard event bit 3 sets on self-test, calibration failure or overload.
// RULE6: Bit 4 sets on execution error, bit 5 on command syntax error.
// RULE7: Bit 7 sets after power cycle; bits 1 and 6 always read zero.
// RULE8: Errors on bits 2 to 5 push the error queue, overload excepted.
// RULE9: Reading overload sets bit 3 and the matching questionable overload bit.
// RULE10: Standard event register clears on clear-status and on its own query.
// RULE11: Standard enable clears on write zero, at power-on only with setting 1.
// RULE12: Questionable bit 0 sets on dc volts overload; unused bits read zero.
// RULE13: Questionable bit 9 sets on resistance range overload.
// RULE14: Questionable bit 10 sets on temperature range overload.
// RULE15: Questionable event clears on clear-status and its event query.
// RULE16: Questionable enable clears at power-on, on preset and on write zero.
// RULE17: Operation condition bit 8 shows filter enabled and settled, per measurement.
// RULE18: Operation event bit latches once the filter has ever settled.
// RULE19: Operation event clears on clear-status and query; enable like questionable.
// RULE20: Message available sets on first reading trigger, clears after all read.
// RULE21: With initiate then fetch, message available sets after all measurements.
// RULE22: Output buffer full before operation-complete stops readings.
// RULE23: Controller clears, sets masks, synchronises, then enables its SRQ; the model's setup task only clears and sets both masks.
// RULE24: Controller may enable bit 0 and poll status bit 5 for long commands.
// RULE25: Service request asserts while any enabled summary bit is set.
package ssr_pkg;
  // ===========================================================
  // Widths and bit positions
  localparam int ESR_W = 8;
  localparam int QUES_W = 16;
  localparam int DATA_W = 16;
  localparam int ESR_OPC = 0;
  localparam int ESR_QUERY = 2;
  localparam int ESR_DEVICE = 3;
  localparam int ESR_EXEC = 4;
  localparam int ESR_CMD = 5;
  localparam int ESR_PON = 7;
  localparam int QUES_DCV = 0;
  localparam int QUES_OHM = 9;
  localparam int QUES_TEMP = 10;
  localparam int OPER_FILT = 8;
  localparam int STB_QUES = 3;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_RQS = 6;
  localparam int STB_OPER = 7;
  // ===========================================================
  // Implemented-bit masks and reset values
  localparam logic [7:0] ESR_USED = 8'hBD;
  localparam logic [15:0] QUES_USED = 16'h0601;
  localparam logic [15:0] OPER_USED = 16'h0100;
  localparam logic [7:0] SRE_USED = 8'hBF;
  localparam logic [7:0] MASK8_RST = 8'h00;
  localparam logic [15:0] MASK16_RST = 16'h0000;
  localparam logic PSC_RST = 1'b0;
  // ===========================================================
  // Commands and carriers
  typedef enum logic [4:0] {
    cmd_none, cmd_cls, cmd_esr_q, cmd_ese_w, cmd_ese_q, cmd_sre_w, cmd_sre_q,
    cmd_stb_q, cmd_qevt_q, cmd_qcond_q, cmd_qena_w, cmd_qena_q, cmd_oevt_q,
    cmd_ocond_q, cmd_oena_w, cmd_oena_q, cmd_preset, cmd_psc_w, cmd_psc_q,
    cmd_opc
  } ssr_cmd_e;
  typedef enum logic {por_load, por_run} ssr_por_e;
  typedef struct packed {
    logic valid;
    ssr_cmd_e code;
    logic [DATA_W-1:0] data;
  } ssr_cmd_s;
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } ssr_rsp_s;
  typedef struct packed {
    logic opc_done;
    logic query_err;
    logic selftest_fail;
    logic cal_fail;
    logic exec_err;
    logic cmd_err;
    logic overload;
    logic ovl_dcv;
    logic ovl_ohm;
    logic ovl_temp;
    logic meas_done;
    logic filter_en;
    logic filter_settled;
    logic first_trigger;
    logic init_mode;
    logic all_meas_done;
    logic out_drained;
    logic out_full;
  } ssr_events_s;
endpackage

// ### ssr_event_group.sv
// One status group: latched event register, enable mask and summary bit.
// Assumes set pulses and clears come from logic on the same clock.
`timescale 1ns/100ps
module ssr_event_group #(
  parameter int W = 16,
  parameter logic [W-1:0] USED = '1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [W-1:0] set_bits,
  input wire logic evt_clr,
  input wire logic ena_we,
  input wire logic [W-1:0] ena_wdata,
  input wire logic ena_clr,
  input wire logic ena_load,
  input wire logic [W-1:0] ena_load_val,
  output logic [W-1:0] evt,
  output logic [W-1:0] ena,
  output logic summary
);
  // ===========================================================
  // Event latch: a set in the clearing cycle survives
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      evt <= '0;
    end else begin
      evt <= ((evt_clr ? '0 : evt) | set_bits) & USED; // [RULE1]
    end
  end

  // ===========================================================
  // Enable mask, untouched by reads
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ena <= '0;
    end else if (ena_load) begin
      ena <= ena_load_val & USED;
    end else if (ena_clr) begin
      ena <= '0;
    end else if (ena_we) begin
      ena <= ena_wdata & USED; // [RULE2]
    end
  end

  assign summary = |(evt & ena); // [RULE2]

  a_evt_holds: assert property ( // [RULE1]
    @(posedge clock) disable iff (!resetn)
    (!evt_clr && (evt != '0)) |=> ((evt & $past(evt)) == $past(evt)))
    else $error("event bit dropped without clear");

  a_ena_steady: assert property ( // [RULE2]
    @(posedge clock) disable iff (!resetn)
    (!ena_we && !ena_clr && !ena_load) |=> $stable(ena))
    else $error("enable mask changed without write");
endmodule

// ### ssr_msg_avail.sv
// Message-available tracker for the status byte.
// Assumes the output buffer logic pulses out_drained when its last message is read.
`timescale 1ns/100ps
module ssr_msg_avail (
  input wire logic clock,
  input wire logic resetn,
  input wire logic first_trigger,
  input wire logic init_mode,
  input wire logic all_meas_done,
  input wire logic out_drained,
  output logic mav
);
  logic set_mav;

  // Initiate mode fills memory first, so only completion counts
  assign set_mav = init_mode ? all_meas_done : first_trigger; // [RULE20] [RULE21]

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mav <= 1'b0;
    end else if (set_mav) begin
      mav <= 1'b1;
    end else if (out_drained) begin
      mav <= 1'b0; // [RULE20]
    end
  end

  a_mav_set: assert property ( // [RULE20]
    @(posedge clock) disable iff (!resetn)
    (first_trigger && !init_mode) |=> mav)
    else $error("message available missed first trigger");

  a_mav_init: assert property ( // [RULE21]
    @(posedge clock) disable iff (!resetn)
    (init_mode && !all_meas_done && !mav) |=> !mav)
    else $error("message available set before measurements done");
endmodule

// ### ssr_status_event_reporting.sv
// Status event reporting: standard, questionable and operation groups,
// status byte, service request and power-on status clear handling.
// Assumes commands, events and polls arrive from logic on the same clock;
// nonvolatile settings are stable when reset is released.
`timescale 1ns/100ps
module ssr_status_event_reporting (
  input wire logic clock,
  input wire logic resetn,
  input wire ssr_pkg::ssr_cmd_s cmd,
  input wire ssr_pkg::ssr_events_s ev,
  input wire logic spoll,
  input wire logic nv_psc,
  input wire logic [7:0] nv_ese,
  input wire logic [7:0] nv_sre,
  output ssr_pkg::ssr_rsp_s rsp,
  output logic [7:0] stb,
  output logic srq,
  output logic err_push,
  output logic stop_readings,
  output logic psc_setting,
  output logic [7:0] ese_mask,
  output logic [7:0] sre_mask
);
  // ===========================================================
  // Declarations
  ssr_pkg::ssr_por_e por_state;
  logic running;
  logic loading;
  logic [7:0] esr_set;
  logic [7:0] esr_evt;
  logic esb_sum;
  logic [15:0] ques_set;
  logic [15:0] ques_evt;
  logic [15:0] ques_ena;
  logic [15:0] ques_cond;
  logic ques_sum;
  logic [15:0] oper_set;
  logic [15:0] oper_evt;
  logic [15:0] oper_ena;
  logic [15:0] oper_cond;
  logic oper_sum;
  logic mav;
  logic [7:0] summary;
  logic service;
  logic service_q;
  logic rqs;
  logic opc_pending;
  logic do_cls;
  logic ese_clear;
  logic [15:0] next_rsp_data;
  logic is_query;

  function automatic logic hit(input ssr_pkg::ssr_cmd_s c, input ssr_pkg::ssr_cmd_e code);
    hit = c.valid && (c.code == code);
  endfunction

  // ===========================================================
  // Power-on sequence
  // Settings are caught one edge after release, never under reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      por_state <= ssr_pkg::por_load;
    end else begin
      case (por_state)
        ssr_pkg::por_load: por_state <= ssr_pkg::por_run;
        ssr_pkg::por_run: por_state <= ssr_pkg::por_run;
        default: por_state <= ssr_pkg::por_load;
      endcase
    end
  end

  assign loading = (por_state == ssr_pkg::por_load);
  assign running = (por_state == ssr_pkg::por_run);
  assign do_cls = running && hit(cmd, ssr_pkg::cmd_cls);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      psc_setting <= ssr_pkg::PSC_RST;
    end else if (loading) begin
      psc_setting <= nv_psc;
    end else if (hit(cmd, ssr_pkg::cmd_psc_w)) begin
      psc_setting <= (cmd.data != 16'h0000);
    end
  end

  // ===========================================================
  // Standard event group
  always_comb begin
    esr_set = 8'h00;
    esr_set[ssr_pkg::ESR_OPC] = running && ev.opc_done; // [RULE3]
    esr_set[ssr_pkg::ESR_QUERY] = running && ev.query_err; // [RULE4]
    esr_set[ssr_pkg::ESR_DEVICE] = running && // [RULE5] [RULE9]
      (ev.selftest_fail || ev.cal_fail || ev.overload);
    esr_set[ssr_pkg::ESR_EXEC] = running && ev.exec_err; // [RULE6]
    esr_set[ssr_pkg::ESR_CMD] = running && ev.cmd_err; // [RULE6]
    esr_set[ssr_pkg::ESR_PON] = loading; // [RULE7]
  end

  // Power-on clear of the mask only when the stored setting asks for it
  assign ese_clear = loading && nv_psc; // [RULE11]

  ssr_event_group #(
    .W(ssr_pkg::ESR_W),
    .USED(ssr_pkg::ESR_USED)
  ) u_esr (
    .clock(clock),
    .resetn(resetn),
    .set_bits(esr_set),
    .evt_clr(do_cls || hit(cmd, ssr_pkg::cmd_esr_q)), // [RULE10]
    .ena_we(running && hit(cmd, ssr_pkg::cmd_ese_w)), // [RULE11]
    .ena_wdata(cmd.data[7:0]),
    .ena_clr(ese_clear),
    .ena_load(loading && !nv_psc),
    .ena_load_val(nv_ese),
    .evt(esr_evt),
    .ena(ese_mask),
    .summary(esb_sum)
  );

  // ===========================================================
  // Questionable data group
  always_comb begin
    ques_set = 16'h0000;
    ques_set[ssr_pkg::QUES_DCV] = running && ev.overload && ev.ovl_dcv; // [RULE12]
    ques_set[ssr_pkg::QUES_OHM] = running && ev.overload && ev.ovl_ohm; // [RULE13]
    ques_set[ssr_pkg::QUES_TEMP] = running && ev.overload && ev.ovl_temp; // [RULE14]
  end

  // Condition view follows the last measurement only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ques_cond <= ssr_pkg::MASK16_RST;
    end else if (ev.meas_done) begin
      ques_cond <= ques_set;
    end
  end

  ssr_event_group #(
    .W(ssr_pkg::QUES_W),
    .USED(ssr_pkg::QUES_USED)
  ) u_ques (
    .clock(clock),
    .resetn(resetn),
    .set_bits(ques_set),
    .evt_clr(do_cls || hit(cmd, ssr_pkg::cmd_qevt_q)), // [RULE15]
    .ena_we(running && hit(cmd, ssr_pkg::cmd_qena_w)),
    .ena_wdata(cmd.data),
    .ena_clr(loading || hit(cmd, ssr_pkg::cmd_preset)), // [RULE16]
    .ena_load(1'b0),
    .ena_load_val(ssr_pkg::MASK16_RST),
    .evt(ques_evt),
    .ena(ques_ena),
    .summary(ques_sum)
  );

  // ===========================================================
  // Operation status group
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      oper_cond <= ssr_pkg::MASK16_RST;
    end else if (ev.meas_done) begin
      oper_cond <= 16'h0000;
      oper_cond[ssr_pkg::OPER_FILT] <= ev.filter_en && ev.filter_settled; // [RULE17]
    end
  end

  always_comb begin
    oper_set = 16'h0000;
    oper_set[ssr_pkg::OPER_FILT] = running && ev.meas_done && // [RULE18]
      ev.filter_en && ev.filter_settled;
  end

  ssr_event_group #(
    .W(ssr_pkg::QUES_W),
    .USED(ssr_pkg::OPER_USED)
  ) u_oper (
    .clock(clock),
    .resetn(resetn),
    .set_bits(oper_set),
    .evt_clr(do_cls || hit(cmd, ssr_pkg::cmd_oevt_q)), // [RULE19]
    .ena_we(running && hit(cmd, ssr_pkg::cmd_oena_w)),
    .ena_wdata(cmd.data),
    .ena_clr(loading || hit(cmd, ssr_pkg::cmd_preset)), // [RULE19]
    .ena_load(1'b0),
    .ena_load_val(ssr_pkg::MASK16_RST),
    .evt(oper_evt),
    .ena(oper_ena),
    .summary(oper_sum)
  );

  // ===========================================================
  // Message available
  ssr_msg_avail u_mav (
    .clock(clock),
    .resetn(resetn),
    .first_trigger(ev.first_trigger),
    .init_mode(ev.init_mode),
    .all_meas_done(ev.all_meas_done),
    .out_drained(ev.out_drained),
    .mav(mav)
  );

  // ===========================================================
  // Status byte and service request
  always_comb begin
    summary = 8'h00;
    summary[ssr_pkg::STB_QUES] = ques_sum;
    summary[ssr_pkg::STB_MAV] = mav;
    summary[ssr_pkg::STB_ESB] = esb_sum;
    summary[ssr_pkg::STB_OPER] = oper_sum;
  end

  assign service = |(summary & sre_mask); // [RULE25]

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sre_mask <= ssr_pkg::MASK8_RST;
    end else if (loading) begin
      sre_mask <= nv_psc ? ssr_pkg::MASK8_RST : (nv_sre & ssr_pkg::SRE_USED);
    end else if (hit(cmd, ssr_pkg::cmd_sre_w)) begin
      sre_mask <= cmd.data[7:0] & ssr_pkg::SRE_USED;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      srq <= 1'b0;
      service_q <= 1'b0;
    end else begin
      srq <= service; // [RULE25]
      service_q <= service;
    end
  end

  // New request beats a poll in the same cycle; cause gone drops it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rqs <= 1'b0;
    end else if (service && !service_q) begin
      rqs <= 1'b1;
    end else if (spoll || !service) begin
      rqs <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stb <= 8'h00;
    end else begin
      stb <= summary;
      stb[ssr_pkg::STB_RQS] <= rqs;
    end
  end

  // ===========================================================
  // Error queue push and reading stop
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      err_push <= 1'b0;
    end else begin
      // Overload alone never reaches the error queue
      err_push <= running && (ev.query_err || ev.selftest_fail || // [RULE8]
        ev.cal_fail || ev.exec_err || ev.cmd_err);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      opc_pending <= 1'b0;
    end else if (running && hit(cmd, ssr_pkg::cmd_opc)) begin
      opc_pending <= 1'b1;
    end else if (ev.opc_done) begin
      opc_pending <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stop_readings <= 1'b0;
    end else begin
      stop_readings <= ev.out_full && opc_pending; // [RULE22]
    end
  end

  // ===========================================================
  // Query answers: value before any clear of the same edge
  always_comb begin
    next_rsp_data = 16'h0000;
    is_query = cmd.valid && running;
    case (cmd.code)
      ssr_pkg::cmd_esr_q: next_rsp_data = {8'h00, esr_evt};
      ssr_pkg::cmd_ese_q: next_rsp_data = {8'h00, ese_mask};
      ssr_pkg::cmd_sre_q: next_rsp_data = {8'h00, sre_mask};
      ssr_pkg::cmd_stb_q: next_rsp_data = {8'h00, stb};
      ssr_pkg::cmd_qevt_q: next_rsp_data = ques_evt;
      ssr_pkg::cmd_qcond_q: next_rsp_data = ques_cond;
      ssr_pkg::cmd_qena_q: next_rsp_data = ques_ena;
      ssr_pkg::cmd_oevt_q: next_rsp_data = oper_evt;
      ssr_pkg::cmd_ocond_q: next_rsp_data = oper_cond;
      ssr_pkg::cmd_oena_q: next_rsp_data = oper_ena;
      ssr_pkg::cmd_psc_q: next_rsp_data = {15'h0000, psc_setting};
      default: is_query = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rsp <= '0;
    end else begin
      rsp.valid <= is_query;
      rsp.data <= next_rsp_data;
    end
  end

  // ===========================================================
  // Checks
  a_ovl_no_err: assert property ( // [RULE8]
    @(posedge clock) disable iff (!resetn)
    (running && ev.overload && !ev.query_err && !ev.selftest_fail && !ev.cal_fail
      && !ev.exec_err && !ev.cmd_err) |=> !err_push)
    else $error("overload pushed an error entry");

  a_err_pushed: assert property ( // [RULE8]
    @(posedge clock) disable iff (!resetn)
    (running && (ev.exec_err || ev.cmd_err)) |=> err_push)
    else $error("error not pushed to queue");
  a_srq_service: assert property ( // [RULE25]
    @(posedge clock) disable iff (!resetn)
    service |=> srq)
    else $error("service request not raised");
  a_stop_full: assert property ( // [RULE22]
    @(posedge clock) disable iff (!resetn)
    (ev.out_full && opc_pending) |=> stop_readings)
    else $error("readings not stopped on full buffer");
  a_esr_unused: assert property ( // [RULE7]
    @(posedge clock) disable iff (!resetn)
    !esr_evt[1] && !esr_evt[6])
    else $error("unused standard event bit set");

  a_pon_flag: assert property ( // [RULE7]
    @(posedge clock) disable iff (!resetn)
    loading |=> esr_evt[ssr_pkg::ESR_PON])
    else $error("power-on bit not set");

  a_ese_psc: assert property ( // [RULE11]
    @(posedge clock) disable iff (!resetn)
    (loading && !nv_psc) |=> (ese_mask == ($past(nv_ese) & ssr_pkg::ESR_USED)))
    else $error("standard enable lost at power-on");

  a_ques_por: assert property ( // [RULE16]
    @(posedge clock) disable iff (!resetn)
    (loading || hit(cmd, ssr_pkg::cmd_preset)) |=> (ques_ena == 16'h0000))
    else $error("questionable enable not cleared");

  a_ques_unused: assert property ( // [RULE12]
    @(posedge clock) disable iff (!resetn)
    (ques_evt & ~ssr_pkg::QUES_USED) == 16'h0000)
    else $error("unused questionable bit set");

  a_oper_cond: assert property ( // [RULE17]
    @(posedge clock) disable iff (!resetn)
    ev.meas_done |=> (oper_cond[ssr_pkg::OPER_FILT] == $past(ev.filter_en && ev.filter_settled)))
    else $error("operation condition bit wrong");

  a_esr_query: assert property ( // [RULE10]
    @(posedge clock) disable iff (!resetn)
    (hit(cmd, ssr_pkg::cmd_esr_q) && esr_set == 8'h00) |=> (esr_evt == 8'h00))
    else $error("standard event not cleared by query");
endmodule

// ### ssr_ctrl_model.sv
// Bus controller model: issues status commands, serial polls, reads replies.
// Assumes a query is answered on the edge that takes it and read at the next falling edge.
`timescale 1ns/100ps
module ssr_ctrl_model (
  input wire logic clock,
  input wire ssr_pkg::ssr_rsp_s rsp,
  output ssr_pkg::ssr_cmd_s cmd,
  output logic spoll
);
  // ===========================================================
  // Requests
  initial begin
    cmd = '0;
    spoll = 1'b0;
  end
  task automatic issue(input ssr_pkg::ssr_cmd_e code, input logic [15:0] data);
    @(negedge clock);
    cmd.valid = 1'b1;
    cmd.code = code;
    cmd.data = data;
    @(negedge clock);
    cmd.valid = 1'b0;
    cmd.code = ssr_pkg::cmd_none;
    // Idle data inverted so a stale write value is never reused
    cmd.data = ~data;
  endtask
  task automatic query(input ssr_pkg::ssr_cmd_e code, output logic [15:0] data);
    issue(code, 16'h0000);
    data = rsp.valid ? rsp.data : 16'hDEAD;
  endtask
  task automatic poll();
    @(negedge clock);
    spoll = 1'b1;
    @(negedge clock);
    spoll = 1'b0;
  endtask
  // ===========================================================
  // Service request setup and long-command completion
  task automatic setup(input logic [15:0] ese, input logic [15:0] sre);
    issue(ssr_pkg::cmd_cls, 16'h0000);
    issue(ssr_pkg::cmd_ese_w, ese);
    issue(ssr_pkg::cmd_sre_w, sre);
  endtask
  task automatic long_cmd();
    setup(16'h0001, 16'h0020);
    issue(ssr_pkg::cmd_opc, 16'h0000);
  endtask
endmodule

// ### ssr_status_event_reporting_test.sv
// Self-checking bench for the status event reporting block.
// Assumes the controller model in ssr_ctrl_model drives the command port.
`timescale 1ns/100ps
module ssr_status_event_reporting_test;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  ssr_pkg::ssr_cmd_s cmd;
  ssr_pkg::ssr_events_s ev = '0;
  ssr_pkg::ssr_events_s lvl = '0;
  ssr_pkg::ssr_rsp_s rsp;
  logic spoll;
  logic nv_psc = 1'b0;
  logic [7:0] nv_ese = 8'h21;
  logic [7:0] nv_sre = 8'h20;
  logic [7:0] stb;
  logic srq, err_push, stop_readings, psc_setting;
  logic [7:0] ese_mask, sre_mask;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  ssr_status_event_reporting ssr_status_event_reporting_inst (
    .clock(clock), .resetn(resetn), .cmd(cmd), .ev(ev), .spoll(spoll),
    .nv_psc(nv_psc), .nv_ese(nv_ese), .nv_sre(nv_sre), .rsp(rsp), .stb(stb),
    .srq(srq), .err_push(err_push), .stop_readings(stop_readings),
    .psc_setting(psc_setting), .ese_mask(ese_mask), .sre_mask(sre_mask)
  );
  ssr_ctrl_model ssr_ctrl_model_inst (
    .clock(clock), .rsp(rsp), .cmd(cmd), .spoll(spoll)
  );
  always #20 clock = ~clock;
  // ===========================================================
  // Shared tasks
  task automatic tally_and_finish();
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Event word bits: 17 opc .. 11 overload, 10 dcv, 9 ohm, 8 temp, 7 meas_done
  task automatic pulse(input logic [17:0] p);
    @(negedge clock);
    ev = ssr_pkg::ssr_events_s'(lvl | p);
    @(negedge clock);
    ev = lvl;
  endtask
  task automatic q(input ssr_pkg::ssr_cmd_e code, input logic [15:0] exp);
    logic [15:0] d;
    ssr_ctrl_model_inst.query(code, d);
    chk(d, exp);
  endtask
  task automatic w(input ssr_pkg::ssr_cmd_e code, input logic [15:0] data);
    ssr_ctrl_model_inst.issue(code, data);
  endtask
  // ===========================================================
  // Scenarios
  task automatic t_power_on();
    chk({8'h00, ese_mask}, 16'h0021);
    chk({8'h00, sre_mask}, 16'h0020);
    q(ssr_pkg::cmd_esr_q, 16'h0080);
    q(ssr_pkg::cmd_esr_q, 16'h0000);
  endtask
  task automatic t_std_events();
    pulse(18'h3B000);
    chk({15'h0000, err_push}, 16'h0001);
    pulse(18'h3B000);
    q(ssr_pkg::cmd_esr_q, 16'h003D);
    pulse(18'h04000);
    q(ssr_pkg::cmd_esr_q, 16'h0008);
    pulse(18'h00C00);
    chk({15'h0000, err_push}, 16'h0000);
    q(ssr_pkg::cmd_esr_q, 16'h0008);
    q(ssr_pkg::cmd_qevt_q, 16'h0001);
    pulse(18'h00A00);
    q(ssr_pkg::cmd_qevt_q, 16'h0200);
    pulse(18'h00900);
    q(ssr_pkg::cmd_qevt_q, 16'h0400);
    q(ssr_pkg::cmd_qevt_q, 16'h0000);
    pulse(18'h00800);
    w(ssr_pkg::cmd_cls, 16'h0000);
    q(ssr_pkg::cmd_qevt_q, 16'h0000);
    q(ssr_pkg::cmd_esr_q, 16'h0000);
  endtask
  task automatic t_summary();
    ssr_ctrl_model_inst.setup(16'h0010, 16'h0020);
    q(ssr_pkg::cmd_ese_q, 16'h0010);
    q(ssr_pkg::cmd_ese_q, 16'h0010);
    pulse(18'h01000);
    idle(3);
    chk({15'h0000, stb[5]}, 16'h0000);
    pulse(18'h02000);
    idle(3);
    chk({13'h0000, stb[6], stb[5], srq}, 16'h0007);
    ssr_ctrl_model_inst.poll();
    idle(3);
    chk({14'h0000, stb[6], srq}, 16'h0001);
    q(ssr_pkg::cmd_stb_q, 16'h0020);
    q(ssr_pkg::cmd_sre_q, 16'h0020);
    q(ssr_pkg::cmd_esr_q, 16'h0030);
    idle(3);
    chk({14'h0000, stb[5], srq}, 16'h0000);
  endtask
  task automatic t_operation();
    w(ssr_pkg::cmd_oena_w, 16'h0100);
    lvl.filter_en = 1'b1;
    lvl.filter_settled = 1'b1;
    pulse(18'h00080);
    q(ssr_pkg::cmd_ocond_q, 16'h0100);
    chk({15'h0000, stb[7]}, 16'h0001);
    lvl.filter_settled = 1'b0;
    pulse(18'h00080);
    q(ssr_pkg::cmd_ocond_q, 16'h0000);
    q(ssr_pkg::cmd_oevt_q, 16'h0100);
    q(ssr_pkg::cmd_oevt_q, 16'h0000);
    lvl.filter_settled = 1'b1;
    pulse(18'h00080);
    w(ssr_pkg::cmd_cls, 16'h0000);
    q(ssr_pkg::cmd_oevt_q, 16'h0000);
    lvl = '0;
    w(ssr_pkg::cmd_qena_w, 16'h0601);
    q(ssr_pkg::cmd_qena_q, 16'h0601);
    pulse(18'h00C80);
    idle(2);
    chk({15'h0000, stb[3]}, 16'h0001);
    q(ssr_pkg::cmd_qcond_q, 16'h0001);
    w(ssr_pkg::cmd_preset, 16'h0000);
    q(ssr_pkg::cmd_qena_q, 16'h0000);
    q(ssr_pkg::cmd_oena_q, 16'h0000);
    w(ssr_pkg::cmd_ese_w, 16'h0000);
    q(ssr_pkg::cmd_ese_q, 16'h0000);
  endtask
  task automatic t_msg_avail();
    pulse(18'h00010);
    idle(3);
    chk({15'h0000, stb[4]}, 16'h0001);
    pulse(18'h00002);
    idle(3);
    chk({15'h0000, stb[4]}, 16'h0000);
    lvl.init_mode = 1'b1;
    pulse(18'h00010);
    idle(3);
    chk({15'h0000, stb[4]}, 16'h0000);
    pulse(18'h00004);
    idle(3);
    chk({15'h0000, stb[4]}, 16'h0001);
    lvl.init_mode = 1'b0;
    pulse(18'h00002);
  endtask
  task automatic t_stop();
    ssr_ctrl_model_inst.long_cmd();
    lvl.out_full = 1'b1;
    pulse(18'h00000);
    idle(2);
    chk({15'h0000, stop_readings}, 16'h0001);
    pulse(18'h20000);
    idle(3);
    chk({14'h0000, stop_readings, srq}, 16'h0001);
    lvl.out_full = 1'b0;
    q(ssr_pkg::cmd_esr_q, 16'h0001);
  endtask
  task automatic t_psc_reset();
    w(ssr_pkg::cmd_psc_w, 16'h0001);
    q(ssr_pkg::cmd_psc_q, 16'h0001);
    chk({15'h0000, psc_setting}, 16'h0001);
    w(ssr_pkg::cmd_qena_w, 16'h0001);
    w(ssr_pkg::cmd_ese_w, 16'h00FF);
    @(negedge clock);
    resetn = 1'b0;
    nv_psc = 1'b1;
    idle(2);
    resetn = 1'b1;
    idle(2);
    chk({ese_mask, sre_mask}, 16'h0000);
    q(ssr_pkg::cmd_qena_q, 16'h0000);
    q(ssr_pkg::cmd_esr_q, 16'h0080);
  endtask
  // ===========================================================
  // Main sequence
  initial begin
    idle(16);
    resetn = 1'b1;
    idle(2);
    t_power_on();
    t_std_events();
    t_summary();
    t_operation();
    t_msg_avail();
    t_stop();
    t_psc_reset();
    tally_and_finish();
  end
endmodule
